// ==== hdl/ccl_loader.v ====
// test-mode calibration and configuration loader
`timescale 1ns/1ps
`default_nettype none
`include "ccl_defs.vh"
// Overview of operation
// - top word bit picks temporal horn pattern when set, continuous when clear
// - end-of-life, battery hush and drift enables are plain on/off bits
// - battery trip field decodes 2.1V..2.8V in a scrambled order
// - emitter current field gives 50, 100, 150 or 200 mA
// - integration time field gives 400, 300, 200 or 100 us
// - amplifier gain field gives factor one to four
// - five six-bit limit and drift fields fill bits 29 down to 0
// - each of the four limits has its own calibration mode
// - calibration routes integrator to green, level to red, comparison to horn
// - each auxiliary clock rise steps the smoke level up
// - interconnect rise with auxiliary clock high starts one integration
// - interconnect rise with auxiliary clock low latches level as mode limit
// - step pulses four to six select hysteresis, hush, chamber modes
// - second interconnect rise after chamber latch commits limits to store
// - eight step pulses select serial loading mode
// - serial order is drift, chamber, hush, hysteresis, normal, then options
// - serial loading mode drives shifted data out on the horn pin
// - interconnect pulse after the word stores the shifted contents
// - in mode eight an auxiliary high of 2ms starts a baseline measurement
// - interconnect pulse with auxiliary clock low stores the baseline
// - hush option bit picks never-cancelled or cancellable hush
module ccl_loader #(
  parameter BASE_MIN_CYC = (`CCL_BASE_MIN_NS + `CCL_CLK_NS - 1) / `CCL_CLK_NS
) (
  input  wire        i_ref_clk,
  input  wire        i_resetn,
  input  wire        i_mode_enable_pin,
  input  wire        i_mode_step_pin,
  input  wire        i_aux_clock_pin,
  input  wire        i_interconnect_pin,
  input  wire        i_integrate_done,
  input  wire [5:0]  i_integrator_level,
  output reg         o_red_indicator_pin,
  output reg         o_green_indicator_pin,
  output reg         o_horn_drive_pin,
  output reg         o_integrate_start,
  output reg         o_measure_busy,
  output reg  [3:0]  o_test_mode,
  output reg  [5:0]  o_smoke_level,
  output reg  [5:0]  o_integrator_value,
  output reg         o_nonvolatile_store,
  output reg  [43:0] o_store_word,
  output reg         o_tone_pattern_select,
  output reg         o_end_of_life_enable,
  output reg         o_battery_hush_enable,
  output reg         o_hush_option,
  output reg         o_drift_enable,
  output reg  [4:0]  o_battery_trip_dv,
  output reg  [7:0]  o_emitter_current_ma,
  output reg  [8:0]  o_integration_time_us,
  output reg  [2:0]  o_amp_gain_select
);
  // ==========================================================
  // decode functions
  function [4:0] batt_dv;
    input [2:0] f;
    begin
      case (f)
        3'h0:    batt_dv = 5'h15;
        3'h1:    batt_dv = 5'h19;
        3'h2:    batt_dv = 5'h17;
        3'h3:    batt_dv = 5'h1B;
        3'h4:    batt_dv = 5'h16;
        3'h5:    batt_dv = 5'h1A;
        3'h6:    batt_dv = 5'h18;
        default: batt_dv = 5'h1C;
      endcase
    end
  endfunction

  function [7:0] irc_ma;
    input [1:0] f;
    begin
      case (f)
        2'h0:    irc_ma = 8'h32;
        2'h1:    irc_ma = 8'h64;
        2'h2:    irc_ma = 8'h96;
        default: irc_ma = 8'hC8;
      endcase
    end
  endfunction

  function [8:0] itim_us;
    input [1:0] f;
    begin
      case (f)
        2'h0:    itim_us = 9'h190;
        2'h1:    itim_us = 9'h12C;
        2'h2:    itim_us = 9'h0C8;
        default: itim_us = 9'h064;
      endcase
    end
  endfunction

  function is_cal;
    input [3:0] m;
    begin
      is_cal = (m >= `CCL_MODE_NORM) && (m <= `CCL_MODE_CHMB);
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  wire [3:0] pin_in;
  wire [3:0] pin_lvl;
  wire [3:0] pin_rise;
  assign pin_in = {i_mode_enable_pin, i_mode_step_pin, i_aux_clock_pin, i_interconnect_pin};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
      ccl_sync_edge u_sync (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_pin     (pin_in[g]),
        .o_level   (pin_lvl[g]),
        .o_rise    (pin_rise[g])
      );
    end
  endgenerate

  wire en_lvl   = pin_lvl[3];
  wire step_lvl = pin_lvl[2];
  wire step_re  = pin_rise[2];
  wire aux_lvl  = pin_lvl[1];
  wire aux_re   = pin_rise[1];
  wire ic_re    = pin_rise[0];

  // ==========================================================
  // state
  reg  [3:0]  mode;
  reg  [43:0] shift_word;
  reg  [43:0] cfg_word;
  reg  [5:0]  limit_norm;
  reg  [5:0]  limit_hyst;
  reg  [5:0]  limit_hush;
  reg  [5:0]  limit_chmb;
  reg         chmb_latched;
  reg         integ_busy;
  reg  [17:0] aux_hi_cnt;
  reg         base_armed;
  reg         base_valid;
  reg  [5:0]  base_value;
  reg  [5:0]  pwm_cnt;

  wire in_cal  = en_lvl && is_cal(mode);
  wire in_ser  = en_lvl && (mode == `CCL_MODE_SER);
  wire base_go = in_ser && aux_lvl && base_armed &&
                 (aux_hi_cnt == BASE_MIN_CYC[17:0] - 18'h00001);

  // ==========================================================
  // mode step counter
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode <= `CCL_MODE_HORN;
    end else if (!en_lvl) begin
      mode <= `CCL_MODE_HORN;
    end else if (step_re && mode != `CCL_MODE_SER) begin
      mode <= mode + 4'h1;
    end
  end

  // ==========================================================
  // calibration: level, integration, limit latch
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_smoke_level      <= 6'h00;
      o_integrator_value <= 6'h00;
      o_integrate_start  <= 1'b0;
      integ_busy         <= 1'b0;
      limit_norm         <= 6'h00;
      limit_hyst         <= 6'h00;
      limit_hush         <= 6'h00;
      limit_chmb         <= 6'h00;
      chmb_latched       <= 1'b0;
    end else begin
      o_integrate_start <= 1'b0;
      if (in_cal && aux_re) begin
        o_smoke_level <= o_smoke_level + 6'h01;
      end
      if (in_cal && ic_re && aux_lvl && !integ_busy) begin
        o_integrate_start <= 1'b1;
        integ_busy        <= 1'b1;
      end
      if ((integ_busy || o_measure_busy) && i_integrate_done) begin
        integ_busy         <= 1'b0;
        o_integrator_value <= i_integrator_level;
      end
      if (in_cal && ic_re && !aux_lvl) begin
        case (mode)
          `CCL_MODE_NORM: limit_norm <= o_smoke_level;
          `CCL_MODE_HYST: limit_hyst <= o_smoke_level;
          `CCL_MODE_HUSH: limit_hush <= o_smoke_level;
          `CCL_MODE_CHMB: begin
            if (!chmb_latched) begin
              limit_chmb   <= o_smoke_level;
              chmb_latched <= 1'b1;
            end
          end
          default: limit_norm <= limit_norm;
        endcase
      end
      if (!en_lvl) begin
        chmb_latched <= 1'b0;
      end
    end
  end

  // ==========================================================
  // serial shift and baseline measurement
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      shift_word     <= `CCL_WORD_RST;
      aux_hi_cnt     <= 18'h00000;
      base_armed     <= 1'b0;
      base_valid     <= 1'b0;
      base_value     <= 6'h00;
      o_measure_busy <= 1'b0;
    end else begin
      if (in_ser && aux_re) begin
        shift_word <= {step_lvl, shift_word[43:1]};
      end
      if (in_ser && aux_lvl) begin
        if (aux_hi_cnt != BASE_MIN_CYC[17:0]) begin
          aux_hi_cnt <= aux_hi_cnt + 18'h00001;
        end
      end else begin
        aux_hi_cnt <= 18'h00000;
      end
      if (in_ser && aux_re) begin
        base_armed <= 1'b1;
      end
      if (base_go && !o_measure_busy) begin
        o_measure_busy <= 1'b1;
        base_armed     <= 1'b0;
      end
      if (o_measure_busy && i_integrate_done) begin
        o_measure_busy <= 1'b0;
        base_value     <= i_integrator_level;
        base_valid     <= 1'b1;
      end
      if (!en_lvl) begin
        base_valid <= 1'b0;
        base_armed <= 1'b0;
      end
    end
  end

  // ==========================================================
  // nonvolatile store commit
  reg [43:0] next_store;
  reg        next_commit;
  always @* begin
    next_store  = cfg_word;
    next_commit = 1'b0;
    if (en_lvl && mode == `CCL_MODE_CHMB && chmb_latched && ic_re && !aux_lvl) begin
      next_commit = 1'b1;
      next_store[`CCL_NORM_LO +: `CCL_FLD_W] = limit_norm;
      next_store[`CCL_HYST_LO +: `CCL_FLD_W] = limit_hyst;
      next_store[`CCL_HUSH_LO +: `CCL_FLD_W] = limit_hush;
      next_store[`CCL_CHMB_LO +: `CCL_FLD_W] = limit_chmb;
    end else if (in_ser && ic_re && !o_measure_busy) begin
      next_commit = 1'b1;
      next_store  = shift_word;
      if (base_valid && !aux_lvl) begin
        next_store[`CCL_DRFT_LO +: `CCL_FLD_W] = base_value;
      end
    end
  end

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_word            <= `CCL_WORD_RST;
      o_store_word        <= `CCL_WORD_RST;
      o_nonvolatile_store <= 1'b0;
    end else begin
      o_nonvolatile_store <= next_commit;
      if (next_commit) begin
        cfg_word     <= next_store;
        o_store_word <= next_store;
      end
    end
  end

  // ==========================================================
  // configuration decode
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tone_pattern_select <= 1'b0;
      o_end_of_life_enable  <= 1'b0;
      o_battery_hush_enable <= 1'b0;
      o_hush_option         <= 1'b0;
      o_drift_enable        <= 1'b0;
      o_battery_trip_dv     <= 5'h15;
      o_emitter_current_ma  <= 8'h32;
      o_integration_time_us <= 9'h190;
      o_amp_gain_select     <= 3'h1;
    end else begin
      o_tone_pattern_select <= cfg_word[`CCL_BIT_TONE];
      o_end_of_life_enable  <= cfg_word[`CCL_BIT_EOL];
      o_battery_hush_enable <= cfg_word[`CCL_BIT_BHUSH];
      o_hush_option         <= cfg_word[`CCL_BIT_HOPT];
      o_drift_enable        <= cfg_word[`CCL_BIT_DRIFT];
      o_battery_trip_dv     <= batt_dv(cfg_word[`CCL_BATT_HI:`CCL_BATT_LO]);
      o_emitter_current_ma  <= irc_ma(cfg_word[`CCL_IRC_HI:`CCL_IRC_LO]);
      o_integration_time_us <= itim_us(cfg_word[`CCL_ITIM_HI:`CCL_ITIM_LO]);
      o_amp_gain_select     <= {1'b0, cfg_word[`CCL_GAIN_HI:`CCL_GAIN_LO]} + 3'h1;
    end
  end

  // ==========================================================
  // indicator and horn outputs
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pwm_cnt               <= 6'h00;
      o_red_indicator_pin   <= 1'b0;
      o_green_indicator_pin <= 1'b0;
      o_horn_drive_pin      <= 1'b0;
      o_test_mode           <= `CCL_MODE_HORN;
    end else begin
      pwm_cnt     <= pwm_cnt + 6'h01;
      o_test_mode <= mode;
      if (in_cal || o_measure_busy) begin
        o_red_indicator_pin   <= (pwm_cnt < o_smoke_level);
        o_green_indicator_pin <= (pwm_cnt < o_integrator_value);
      end else begin
        o_red_indicator_pin   <= 1'b0;
        o_green_indicator_pin <= 1'b0;
      end
      if (in_cal) begin
        o_horn_drive_pin <= (o_smoke_level < o_integrator_value);
      end else if (in_ser) begin
        o_horn_drive_pin <= shift_word[0];
      end else begin
        o_horn_drive_pin <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/ccl_defs.vh ====
// constants for the calibration and configuration loader
`ifndef CCL_DEFS_VH
`define CCL_DEFS_VH
`define CCL_WORD_W        44
`define CCL_WORD_RST      44'h000_0000_0000
`define CCL_STEP_W        4
`define CCL_MODE_HORN     4'h0
`define CCL_MODE_NORM     4'h3
`define CCL_MODE_HYST     4'h4
`define CCL_MODE_HUSH     4'h5
`define CCL_MODE_CHMB     4'h6
`define CCL_MODE_SER      4'h8
`define CCL_BIT_TONE      43
`define CCL_BIT_EOL       42
`define CCL_BIT_BHUSH     41
`define CCL_BIT_HOPT      40
`define CCL_BIT_DRIFT     39
`define CCL_BATT_HI       38
`define CCL_BATT_LO       36
`define CCL_IRC_HI        35
`define CCL_IRC_LO        34
`define CCL_ITIM_HI       33
`define CCL_ITIM_LO       32
`define CCL_GAIN_HI       31
`define CCL_GAIN_LO       30
`define CCL_NORM_LO       24
`define CCL_HYST_LO       18
`define CCL_HUSH_LO       12
`define CCL_CHMB_LO       6
`define CCL_DRFT_LO       0
`define CCL_FLD_W         6
`define CCL_CLK_NS        10
`define CCL_BASE_MIN_NS   2000000
`define CCL_BASE_CNT_W    18
`endif

// ==== hdl/ccl_sync_edge.v ====
// three-stage pin synchroniser with agreement filter and rise detect
`timescale 1ns/1ps
`default_nettype none
module ccl_sync_edge (
  input  wire i_ref_clk,
  input  wire i_resetn,
  input  wire i_pin,
  output reg  o_level,
  output reg  o_rise
);
  reg s1;
  reg s2;
  reg s3;
  // ==========================================================
  // sync and edge
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1      <= 1'b0;
      s2      <= 1'b0;
      s3      <= 1'b0;
      o_level <= 1'b0;
      o_rise  <= 1'b0;
    end else begin
      s1     <= i_pin;
      s2     <= s1;
      s3     <= s2;
      o_rise <= 1'b0;
      if (s2 == s3) begin
        o_level <= s3;
        o_rise  <= s3 & ~o_level;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/ccl_loader_asserts.sv ====
// concurrent checks on the loader top-level ports
`timescale 1ns/1ps
`default_nettype none
module ccl_loader_asserts (
  input wire logic        i_ref_clk,
  input wire logic        i_resetn,
  input wire logic        i_mode_enable_pin,
  input wire logic        i_integrate_done,
  input wire logic [5:0]  i_integrator_level,
  input wire logic        o_horn_drive_pin,
  input wire logic        o_integrate_start,
  input wire logic [3:0]  o_test_mode,
  input wire logic [5:0]  o_smoke_level,
  input wire logic [5:0]  o_integrator_value,
  input wire logic        o_nonvolatile_store,
  input wire logic [43:0] o_store_word,
  input wire logic        o_tone_pattern_select,
  input wire logic        o_end_of_life_enable,
  input wire logic        o_battery_hush_enable,
  input wire logic        o_hush_option,
  input wire logic        o_drift_enable,
  input wire logic [4:0]  o_battery_trip_dv,
  input wire logic [7:0]  o_emitter_current_ma,
  input wire logic [8:0]  o_integration_time_us,
  input wire logic [2:0]  o_amp_gain_select
);
  // ==========================================
  // properties
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_one(sig);
    sig ##1 !sig;
  endsequence
  property p_store_pulse;
    $rose(o_nonvolatile_store) |-> s_one(o_nonvolatile_store);
  endproperty
  property p_start_pulse;
    $rose(o_integrate_start) |-> s_one(o_integrate_start);
  endproperty
  property p_mode_max;
    o_test_mode <= 4'h8;
  endproperty
  property p_mode_step;
    o_test_mode != $past(o_test_mode) |-> o_test_mode == $past(o_test_mode) + 4'h1 || o_test_mode == 4'h0;
  endproperty
  property p_mode_clear;
    !i_mode_enable_pin [*8] |-> o_test_mode == 4'h0;
  endproperty
  property p_level_step;
    $past(o_test_mode) inside {[4'h3:4'h6]} && o_smoke_level != $past(o_smoke_level)
      |-> o_smoke_level == $past(o_smoke_level) + 6'h01;
  endproperty
  property p_capture;
    i_integrate_done |=> o_integrator_value == $past(i_integrator_level);
  endproperty
  property p_horn_cal;
    i_mode_enable_pin && o_test_mode inside {[4'h3:4'h6]} && $stable(o_test_mode)
      && $stable(o_smoke_level) && $stable(o_integrator_value)
      |-> o_horn_drive_pin == (o_smoke_level < o_integrator_value);
  endproperty
  property p_trip;
    !o_nonvolatile_store |-> o_battery_trip_dv == 5'h15 + 5'(o_store_word[36]) * 5'h4
      + 5'(o_store_word[37]) * 5'h2 + 5'(o_store_word[38]);
  endproperty
  property p_fields;
    !o_nonvolatile_store |-> o_emitter_current_ma == 8'h32 + 8'h32 * o_store_word[35:34]
      && o_integration_time_us == 9'h190 - 9'h064 * o_store_word[33:32]
      && o_amp_gain_select == 3'h1 + o_store_word[31:30]
      && {o_tone_pattern_select, o_end_of_life_enable, o_battery_hush_enable, o_hush_option, o_drift_enable}
         == o_store_word[43:39];
  endproperty
  a_store_pulse: assert property (p_store_pulse) else $error("store pulse too long");
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  a_mode_max: assert property (p_mode_max) else $error("mode above eight");
  a_mode_step: assert property (p_mode_step) else $error("mode jumped");
  a_mode_clear: assert property (p_mode_clear) else $error("mode not cleared");
  a_level_step: assert property (p_level_step) else $error("level step wrong");
  a_capture: assert property (p_capture) else $error("integration not captured");
  a_horn_cal: assert property (p_horn_cal) else $error("horn compare wrong");
  a_trip: assert property (p_trip) else $error("trip decode wrong");
  a_fields: assert property (p_fields) else $error("field decode wrong");
endmodule
bind ccl_loader ccl_loader_asserts ccl_loader_asserts_i (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_mode_enable_pin(i_mode_enable_pin),
  .i_integrate_done(i_integrate_done), .i_integrator_level(i_integrator_level),
  .o_horn_drive_pin(o_horn_drive_pin), .o_integrate_start(o_integrate_start), .o_test_mode(o_test_mode),
  .o_smoke_level(o_smoke_level), .o_integrator_value(o_integrator_value),
  .o_nonvolatile_store(o_nonvolatile_store), .o_store_word(o_store_word),
  .o_tone_pattern_select(o_tone_pattern_select), .o_end_of_life_enable(o_end_of_life_enable),
  .o_battery_hush_enable(o_battery_hush_enable), .o_hush_option(o_hush_option),
  .o_drift_enable(o_drift_enable), .o_battery_trip_dv(o_battery_trip_dv),
  .o_emitter_current_ma(o_emitter_current_ma), .o_integration_time_us(o_integration_time_us),
  .o_amp_gain_select(o_amp_gain_select)
);
`default_nettype wire

// ==== tb/ccl_fixture.sv ====
// analog integrator stand-in answering integration and baseline requests
`timescale 1ns/1ps
`default_nettype none
module ccl_fixture #(
  parameter logic [5:0] LVL = 6'h2A
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_start,
  input  wire logic       i_busy,
  output logic            o_done,
  output logic [5:0]      o_level
);
  // ==========================================
  // delayed one-cycle answer, level scrambled otherwise
  logic       busy_q;
  logic [3:0] cnt;
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_q <= 1'b0;
      cnt <= 4'h0;
      o_done <= 1'b0;
      o_level <= 6'h15;
    end else begin
      busy_q <= i_busy;
      o_done <= (cnt == 4'h1);
      o_level <= (cnt == 4'h1) ? LVL : ~o_level;
      if (i_start || (i_busy && !busy_q)) begin
        cnt <= 4'h5;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/test_calibration_config_loader.sv ====
// self-checking bench for the calibration and configuration loader
`timescale 1ns/1ps
`default_nettype none
module test_calibration_config_loader;
  // ==========================================
  // signals and instances
  localparam int         BMIN = 20;
  localparam logic [5:0] LVL  = 6'h2A;
  logic clk, rstn, en, stp, aux, ic, done, red, grn, horn, istart, busy, nvs;
  logic tone, end_of_life_enable, bh, hopt, dren;
  logic [5:0]  lvl, slev, ival;
  logic [3:0]  mode;
  logic [43:0] sw;
  logic [4:0]  trip;
  logic [7:0]  cur;
  logic [8:0]  itime;
  logic [2:0]  gain;
  int          num_errors, n_tests;
  ccl_loader #(.BASE_MIN_CYC(BMIN)) ccl_loader_i (
    .i_ref_clk(clk), .i_resetn(rstn), .i_mode_enable_pin(en), .i_mode_step_pin(stp),
    .i_aux_clock_pin(aux), .i_interconnect_pin(ic), .i_integrate_done(done), .i_integrator_level(lvl),
    .o_red_indicator_pin(red), .o_green_indicator_pin(grn), .o_horn_drive_pin(horn),
    .o_integrate_start(istart), .o_measure_busy(busy), .o_test_mode(mode), .o_smoke_level(slev),
    .o_integrator_value(ival), .o_nonvolatile_store(nvs), .o_store_word(sw),
    .o_tone_pattern_select(tone), .o_end_of_life_enable(end_of_life_enable), .o_battery_hush_enable(bh),
    .o_hush_option(hopt), .o_drift_enable(dren), .o_battery_trip_dv(trip),
    .o_emitter_current_ma(cur), .o_integration_time_us(itime), .o_amp_gain_select(gain));
  ccl_fixture #(.LVL(LVL)) ccl_fixture_i (
    .i_ref_clk(clk), .i_resetn(rstn), .i_start(istart), .i_busy(busy), .o_done(done), .o_level(lvl));
  // ==========================================
  // helpers
  task automatic chk(input logic [43:0] got, input logic [43:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse_step();
    stp <= 1'b1;
    cyc(8);
    stp <= 1'b0;
    cyc(8);
  endtask
  task automatic pulse_aux(input logic d);
    stp <= d;
    cyc(4);
    aux <= 1'b1;
    cyc(4);
    aux <= 1'b0;
    cyc(4);
  endtask
  task automatic duty(output int nr, output int ng);
    nr = 0;
    ng = 0;
    repeat (64) begin
      @(posedge clk);
      #1 nr += red;
      ng += grn;
    end
  endtask
  task automatic pulse_ic(output logic st);
    st = 1'b0;
    ic <= 1'b1;
    repeat (12) begin
      @(posedge clk);
      #1 if (nvs === 1'b1) st = 1'b1;
    end
    ic <= 1'b0;
    cyc(8);
  endtask
  task automatic results();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    chk(trip, 5'h15);
    chk(cur, 8'h32);
    chk(itime, 9'h190);
    chk(gain, 3'h1);
  endtask
  task automatic t_cal();
    logic [5:0]  base;
    logic [5:0]  e;
    logic [23:0] lims;
    logic        st;
    int          nr;
    int          ng;
    en <= 1'b1;
    cyc(8);
    repeat (3) pulse_step();
    for (int m = 0; m < 4; m++) begin
      if (m > 0) pulse_step();
      chk(mode, 4'(m + 3));
      base = slev;
      e = base + 6'(m + 3);
      repeat (m + 2) pulse_aux(1'b0);
      aux <= 1'b1;
      cyc(4);
      pulse_ic(st);
      chk(slev, e);
      chk(ival, LVL);
      chk(horn, e < LVL);
      duty(nr, ng);
      chk(nr, e);
      chk(ng, LVL);
      aux <= 1'b0;
      cyc(8);
      pulse_ic(st);
      chk(st, 1'b0);
      lims = {lims[17:0], e};
    end
    pulse_ic(st);
    chk(st, 1'b1);
    chk(sw[29:6], lims);
    en <= 1'b0;
    cyc(10);
    chk(mode, 4'h0);
  endtask
  task automatic load_word(input logic [43:0] w);
    logic st;
    for (int b = 0; b < 44; b++) pulse_aux(w[b]);
    cyc(8);
    chk(horn, w[0]);
    pulse_ic(st);
    chk(st, 1'b1);
    chk(sw, w);
    chk({tone, end_of_life_enable, bh, hopt, dren}, w[43:39]);
    chk(trip, 5'h15 + 5'({w[36], w[37], w[38]}));
    chk(cur, 8'h32 + 8'h32 * 8'(w[35:34]));
    chk(itime, 9'h190 - 9'h064 * 9'(w[33:32]));
    chk(gain, 3'h1 + 3'(w[31:30]));
  endtask
  task automatic t_serial();
    logic [43:0] w;
    logic        bseen;
    logic        st;
    en <= 1'b1;
    cyc(8);
    repeat (9) pulse_step();
    chk(mode, 4'h8);
    for (int i = 0; i < 8; i++) begin
      w = {5'(i * 7), 3'(i), 2'(i), 2'(i + 1), 2'(i + 2), 6'(i * 5 + 1), 6'(i * 3 + 2), 6'(i * 11), 6'(63 - i),
           6'(i * 7 + 4)};
      load_word(w);
    end
    stp <= 1'b0;
    cyc(4);
    aux <= 1'b1;
    bseen = 1'b0;
    repeat (BMIN + 20) begin
      @(posedge clk);
      #1 if (busy === 1'b1) bseen = 1'b1;
    end
    chk(bseen, 1'b1);
    aux <= 1'b0;
    cyc(8);
    pulse_ic(st);
    chk(st, 1'b1);
    chk(sw, {1'b0, w[43:7], LVL});
  endtask
  // ==========================================
  // clock, reset, sequence, watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    en = 1'b0;
    stp = 1'b0;
    aux = 1'b0;
    ic = 1'b0;
    num_errors = 0;
    n_tests = 0;
    cyc(8);
    rstn <= 1'b1;
    cyc(2);
    t_reset();
    t_cal();
    t_serial();
    results();
  end
  initial begin
    #300000;
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
